// ===== pbwpc_ctrl.sv
// Purpose: Wiper position control from two active-low step inputs and a save input
// Assumes: Inputs synchronous to core_clk; rst_b marks power-up, supply_ok low marks power loss
// Notes: Nonvolatile cell is outside; this block loads from it and issues write strobes
`timescale 1ns/1ps
`default_nettype none
module pbwpc_ctrl #(
   parameter int TICK_DIV = pbwpc_pkg::TICK_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic step_up_button_n,
   input wire logic step_down_button_n,
   input wire logic save_trigger,
   input wire logic supply_ok,
   input wire logic [pbwpc_pkg::POS_W-1:0] saved_pos,
   output logic [pbwpc_pkg::POS_W-1:0] wiper_pos,
   output logic nv_write,
   output logic [pbwpc_pkg::POS_W-1:0] nv_data,
   output logic store_busy,
   output logic cmd_mode
);
   import pbwpc_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic started;
      logic cmd_mode;
      logic [POS_W-1:0] pos;
      logic [TK_W-1:0] lock_tk;
      pbwpc_btn_e btn;
      logic dir_up;
      logic [TK_W-1:0] low_tk;
      logic [TK_W-1:0] high_tk;
      logic [TK_W-1:0] rep_tk;
      logic save_q;
      logic [7:0] save_cyc;
      logic save_arm;
      logic busy;
      logic [TK_W-1:0] store_tk;
      logic supply_q;
      logic auto_done;
      logic nv_write;
      logic [POS_W-1:0] nv_data;
   } pbwpc_ctrl_s;

   pbwpc_ctrl_s st, next_st;
   logic tick;

   pbwpc_tick #(
      .DIV(TICK_DIV)
   ) u_tick (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .tick(tick)
   );

   // Saturating step; holds at either end
   function automatic logic [POS_W-1:0] step_pos(input logic [POS_W-1:0] p, input logic up);
      if (up) begin
         step_pos = (p == POS_W'(POS_STEPS - 1)) ? p : p + 1'b1;
      end else begin
         step_pos = (p == '0) ? p : p - 1'b1;
      end
   endfunction : step_pos

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic up_low, dn_low, act_low, one_low;
   always_comb begin
      next_st = st;
      next_st.nv_write = 1'b0;
      up_low = !step_up_button_n;
      dn_low = !step_down_button_n;
      act_low = st.dir_up ? up_low : dn_low;
      one_low = up_low ^ dn_low;
      next_st.save_q = save_trigger;
      next_st.supply_q = supply_ok;
      if (!st.started) begin
         // Straps and restore caught on the first clock after release
         next_st.started = 1'b1;
         next_st.cmd_mode = !save_trigger;
         next_st.pos = saved_pos;
         next_st.high_tk = '0;
      end else begin
         // Storage request detection; it wins over the buttons
         if (st.cmd_mode && supply_ok) begin
            if (save_trigger && !st.save_q) begin
               next_st.save_arm = 1'b1;
               next_st.save_cyc = '0;
               next_st.store_tk = '0;
            end else if (st.save_arm && save_trigger) begin
               if (st.save_cyc == 8'(SAVE_PULSE_CYC - 1)) begin
                  next_st.save_arm = 1'b0;
                  next_st.busy = 1'b1;
                  next_st.nv_write = 1'b1;
                  next_st.nv_data = st.pos;
               end else begin
                  next_st.save_cyc = st.save_cyc + 8'h01;
               end
            end else if (!save_trigger) begin
               next_st.save_arm = 1'b0;
            end
         end
         if (!st.cmd_mode && st.supply_q && !supply_ok && !st.auto_done) begin
            next_st.auto_done = 1'b1;
            next_st.nv_write = 1'b1;
            next_st.nv_data = st.pos;
            next_st.busy = 1'b1;
            next_st.store_tk = '0;
         end
         // A store launched this cycle already freezes the buttons, so nv_data matches the position
         if (st.busy || st.save_arm || next_st.busy) begin
            // Store counter measured from the save rising edge, or from the power-loss write for an auto store
            if (tick && st.busy) begin
               if (st.store_tk >= TK_W'(STORE_TK - 1)) begin
                  next_st.busy = !(st.cmd_mode);
               end
               next_st.store_tk = st.store_tk + 1'b1;
            end
            if (tick && st.save_arm) begin
               next_st.store_tk = st.store_tk + 1'b1;
            end
            // Button state frozen here; resumes after a command-mode store, but an auto store keeps it frozen until reset
         end else if (st.lock_tk < TK_W'(LOCKOUT_TK)) begin
            if (tick) begin
               next_st.lock_tk = st.lock_tk + 1'b1;
            end
            next_st.btn = PBWPC_IDLE;
            next_st.high_tk = '0;
         end else if (tick) begin
            // All button pulse timing in ticks; the save pulse is counted in core_clk cycles
            case (st.btn)
               PBWPC_IDLE: begin
                  if (!up_low && !dn_low && st.high_tk != TK_W'(MIN_PULSE_TK)) begin
                     next_st.high_tk = st.high_tk + 1'b1;
                  end
                  if (one_low && st.high_tk == TK_W'(MIN_PULSE_TK)) begin
                     next_st.btn = PBWPC_PRESS;
                     next_st.dir_up = up_low;
                     next_st.low_tk = TK_W'(1);
                  end else if (up_low || dn_low) begin
                     next_st.high_tk = '0;
                  end
               end
               PBWPC_PRESS: begin
                  if (up_low && dn_low) begin
                     next_st.low_tk = st.low_tk;
                  end else if (!act_low) begin
                     if (st.low_tk > TK_W'(MIN_PULSE_TK)) begin
                        next_st.pos = step_pos(st.pos, st.dir_up);
                        next_st.high_tk = TK_W'(1);
                     end else begin
                        // Too short to count: a bounce, so the real press that follows is not lost
                        next_st.high_tk = TK_W'(MIN_PULSE_TK);
                     end
                     next_st.btn = PBWPC_IDLE;
                  end else if (st.low_tk == TK_W'(HOLD_TK)) begin
                     next_st.pos = step_pos(st.pos, st.dir_up);
                     next_st.btn = PBWPC_REPEAT;
                     next_st.rep_tk = TK_W'(1);
                  end else begin
                     next_st.low_tk = st.low_tk + 1'b1;
                  end
               end
               PBWPC_REPEAT: begin
                  if (!act_low) begin
                     next_st.btn = PBWPC_IDLE;
                     next_st.high_tk = TK_W'(1);
                  end else if (up_low && dn_low) begin
                     next_st.rep_tk = st.rep_tk;
                  end else if (st.rep_tk == TK_W'(REPEAT_TK)) begin
                     next_st.pos = step_pos(st.pos, st.dir_up);
                     next_st.rep_tk = TK_W'(1);
                  end else begin
                     next_st.rep_tk = st.rep_tk + 1'b1;
                  end
               end
               default: begin
                  next_st.btn = PBWPC_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign wiper_pos = st.pos;
   assign nv_write = st.nv_write;
   assign nv_data = st.nv_data;
   assign store_busy = st.busy;
   assign cmd_mode = st.cmd_mode;
endmodule : pbwpc_ctrl
`default_nettype wire

// ===== pbwpc_pkg.sv
// Purpose: Constants for the pushbutton wiper position controller
// Assumes: 100 MHz core clock
// Notes: Times in their own unit, counts derived
package pbwpc_pkg;
   localparam int POS_STEPS = 64;
   localparam int POS_W = 6;
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 100;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   localparam int MIN_PULSE_MS = 1;
   localparam int HOLD_MS = 500;
   localparam int REPEAT_MS = 100;
   localparam int LOCKOUT_MS = 10;
   localparam int STORE_MS = 4;
   localparam int SAVE_PULSE_US = 1;
   localparam int MIN_PULSE_TK = (MIN_PULSE_MS * 1000 + TICK_US - 1) / TICK_US;
   localparam int HOLD_TK = (HOLD_MS * 1000) / TICK_US;
   localparam int REPEAT_TK = (REPEAT_MS * 1000) / TICK_US;
   localparam int LOCKOUT_TK = (LOCKOUT_MS * 1000 + TICK_US - 1) / TICK_US;
   localparam int STORE_TK = (STORE_MS * 1000 + TICK_US - 1) / TICK_US;
   localparam int SAVE_PULSE_CYC = (SAVE_PULSE_US * CLK_MHZ > 1) ? SAVE_PULSE_US * CLK_MHZ : 1;
   localparam int TK_W = 13;
   localparam logic [POS_W-1:0] POS_RESET = 6'h00;
   typedef enum logic [1:0] {PBWPC_IDLE, PBWPC_PRESS, PBWPC_REPEAT, PBWPC_WAIT_REL} pbwpc_btn_e;
endpackage : pbwpc_pkg

// ===== pbwpc_tick.sv
// Purpose: Divider giving the internal timebase tick
// Assumes: Single clock domain
// Notes: One-cycle pulse every DIV cycles, TICK_CYC by default
`timescale 1ns/1ps
`default_nettype none
module pbwpc_tick #(
   parameter int DIV = pbwpc_pkg::TICK_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   output logic tick
);
   import pbwpc_pkg::*;
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } pbwpc_tick_s;
   pbwpc_tick_s st, next_st;
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (st.cnt == 16'(DIV - 1)) begin
         next_st.cnt = 16'h0000;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 16'h0001;
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign tick = st.tick;
endmodule : pbwpc_tick
`default_nettype wire

// ===== pbwpc_ctrl_assertions.sv
// Purpose: Port checks for pbwpc_ctrl
// Assumes: One clock, rst_b async low
// Notes: age skips the power-up load edge
`timescale 1ns/1ps
`default_nettype none
module pbwpc_chk #(
   parameter int TICK_DIV = pbwpc_pkg::TICK_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic step_up_button_n,
   input wire logic step_down_button_n,
   input wire logic save_trigger,
   input wire logic [pbwpc_pkg::POS_W-1:0] saved_pos,
   input wire logic [pbwpc_pkg::POS_W-1:0] wiper_pos,
   input wire logic nv_write,
   input wire logic [pbwpc_pkg::POS_W-1:0] nv_data,
   input wire logic store_busy,
   input wire logic cmd_mode
);
   import pbwpc_pkg::*;
   localparam int LOCK_CYC = LOCKOUT_TK * TICK_DIV;
   logic [1:0] age;
   logic [20:0] up_cyc;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         age <= 2'h0;
         up_cyc <= 21'h0;
      end else begin
         age <= (age == 2'h3) ? age : age + 2'h1;
         up_cyc <= (up_cyc >= 21'(LOCK_CYC)) ? up_cyc : up_cyc + 21'h1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_power_load: assert property (age == 2'h1 |-> wiper_pos == $past(saved_pos))
      else $error("bad load");
   a_mode_strap: assert property (age == 2'h1 |->
      (cmd_mode == !$past(save_trigger)) ##1 $stable(cmd_mode) [*8]) else $error("bad mode");
   a_single_step: assert property (age == 2'h3 && $changed(wiper_pos) |->
      wiper_pos == $past(wiper_pos) + 7'h01 || $past(wiper_pos) == wiper_pos + 7'h01) else $error("bad step");
   a_lockout_hold: assert property (age == 2'h3 && up_cyc < 21'(LOCK_CYC) |-> $stable(wiper_pos))
      else $error("moved in lockout");
   a_store_freeze: assert property (age == 2'h3 && $past(store_busy) |-> $stable(wiper_pos))
      else $error("moved in store");
   a_both_low: assert property (age == 2'h3 && !step_up_button_n && !step_down_button_n
      |=> $stable(wiper_pos)) else $error("moved with both low");
   a_write_data: assert property (nv_write |-> nv_data == wiper_pos)
      else $error("bad write data");
   a_cmd_held: assert property (nv_write && cmd_mode |-> $past(save_trigger))
      else $error("write without save");
   c_cmd_store: cover property (nv_write && cmd_mode);
   c_auto_store: cover property (nv_write && !cmd_mode);
   c_top_end: cover property (wiper_pos == 6'h3f);
endmodule : pbwpc_chk
bind pbwpc_ctrl pbwpc_chk #(.TICK_DIV(TICK_DIV)) u_chk (.core_clk(core_clk), .rst_b(rst_b),
   .step_up_button_n(step_up_button_n),
   .step_down_button_n(step_down_button_n), .save_trigger(save_trigger), .saved_pos(saved_pos),
   .wiper_pos(wiper_pos), .nv_write(nv_write), .nv_data(nv_data), .store_busy(store_busy), .cmd_mode(cmd_mode));
`default_nettype wire

// ===== pbwpc_btn_model.sv
// Purpose: Buttons or host on the step inputs
// Assumes: Changes land 1 ns after a clock rise
// Notes: Times in ticks of DIV cycles; bounce toggles every 3 cycles, under one tick
`timescale 1ns/1ps
`default_nettype none
module pbwpc_btn_model #(
   parameter int DIV = pbwpc_pkg::TICK_CYC
) (
   input wire logic core_clk,
   output var logic step_up_button_n,
   output var logic step_down_button_n
);
   initial {step_up_button_n, step_down_button_n} = 2'h3;
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wait_cyc
   task automatic press(input logic up, input logic dn, input int low_tk, input int bounce, input int gap_tk);
      for (int i = 0; i <= bounce; i++) begin
         {step_up_button_n, step_down_button_n} = {~up, ~dn};
         wait_cyc((i == bounce) ? low_tk * DIV : 3);
         {step_up_button_n, step_down_button_n} = 2'h3;
         wait_cyc((i == bounce) ? gap_tk * DIV : 3);
      end
   endtask : press
endmodule : pbwpc_btn_model
`default_nettype wire

// ===== tb_pushbutton_wiper_position_ctrl.sv
// Purpose: Self-checking bench for pbwpc_ctrl
// Assumes: Tick shortened to TB_DIV cycles so the run stays small; times below in ticks
// Notes: Hold-repeat not exercised here or in the checker, 0.5 s is too slow here
`timescale 1ns/1ps
`default_nettype none
module tb_pushbutton_wiper_position_ctrl;
   import pbwpc_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b, save_trigger, supply_ok, step_up_button_n, step_down_button_n, nv_write, store_busy, cmd_mode;
   logic [POS_W-1:0] saved_pos, wiper_pos, nv_data;
   int fails = 0, check_count = 0;
   localparam int TB_DIV = 50;
   pbwpc_ctrl #(.TICK_DIV(TB_DIV)) dut (.core_clk(core_clk), .rst_b(rst_b), .step_up_button_n(step_up_button_n),
      .step_down_button_n(step_down_button_n), .save_trigger(save_trigger), .supply_ok(supply_ok),
      .saved_pos(saved_pos), .wiper_pos(wiper_pos), .nv_write(nv_write), .nv_data(nv_data),
      .store_busy(store_busy), .cmd_mode(cmd_mode));
   pbwpc_btn_model #(.DIV(TB_DIV)) btn (.core_clk(core_clk), .step_up_button_n(step_up_button_n),
      .step_down_button_n(step_down_button_n));
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic wait_write();
      for (int n = 0; n < 300 && nv_write !== 1'b1; n++) begin
         @(posedge core_clk);
         #1;
      end
      check(nv_write, 8'h01);
      if (nv_write !== 1'b1) stop_test();
   endtask : wait_write
   // A press inside the lockout must be lost
   task automatic power_up(input logic strap, input logic [POS_W-1:0] pos);
      rst_b = 1'b0;
      save_trigger = strap;
      saved_pos = pos;
      supply_ok = 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      btn.press(1'b1, 1'b0, 20, 0, 120);
      check(wiper_pos, 8'(pos));
      check(cmd_mode, 8'(!strap));
      $display("power-up done");
   endtask : power_up
   task automatic t_steps();
      btn.press(1'b1, 1'b0, 20, 0, 20);
      check(wiper_pos, 8'h3f);
      btn.press(1'b1, 1'b0, 20, 0, 20);
      check(wiper_pos, 8'h3f);
      btn.press(1'b0, 1'b1, 20, 0, 20);
      check(wiper_pos, 8'h3e);
      btn.press(1'b0, 1'b1, 5, 0, 20);
      check(wiper_pos, 8'h3e);
      btn.press(1'b0, 1'b1, 20, 3, 5);
      btn.press(1'b0, 1'b1, 20, 0, 20);
      check(wiper_pos, 8'h3d);
      btn.press(1'b1, 1'b1, 20, 0, 20);
      check(wiper_pos, 8'h3d);
      $display("steps done");
   endtask : t_steps
   task automatic t_store();
      supply_ok = 1'b0;
      wait_write();
      check(nv_data, 8'h3d);
      power_up(1'b0, 6'h05);
      btn.press(1'b1, 1'b0, 20, 0, 20);
      save_trigger = 1'b1;
      wait_write();
      check(nv_data, 8'h06);
      btn.wait_cyc(200);
      save_trigger = 1'b0;
      btn.press(1'b1, 1'b0, 20, 0, 10);
      check(store_busy, 8'h01);
      check(wiper_pos, 8'h06);
      btn.wait_cyc(15 * TB_DIV);
      check(store_busy, 8'h00);
      $display("store done");
   endtask : t_store
   initial begin
      power_up(1'b1, 6'h3e);
      t_steps();
      t_store();
      stop_test();
   end
endmodule : tb_pushbutton_wiper_position_ctrl
`default_nettype wire
